// ==== src/lpr_top.sv ====
// Overview of operation
// - Low-power entry clears mask, stops processor clock
// - Wait keeps peripheral clocks, stops processor clocks
// - Wait interrupt wake stacks one cycle later
// - Reset or break ends wait; break sets flag
// - Watchdog keeps running in wait when enabled
// - Stop clears counter and gates all three clocks
// - Interrupt, break end stop after recovery; reset ends it at once
// - Recovery is 4096 cycles, or 32 when short
// - Counter held through stop, then times recovery
// - Registers decoded at FE00, FE01, FE03
// - Break-wait flag cleared by zero write, reset
// - Reading reset-cause register clears all flags except a cause raised in that cycle
// - Power-on sets its flag, clears others
// - Other resets set own flag, keep others
// - Separate flags for each reset source
// - Clear-enable bit gates flag clearing in other modules during break
// - Twelve-bit counter overflow clocks the watchdog
// - Clears in break stick; two-step clears protected
`timescale 1ns/1ps
`default_nettype none
module lpr_top
  import lpr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic WAIT_EXEC,
  input wire logic STOP_EXEC,
  input wire logic MOD_IRQ,
  input wire logic BREAK_IRQ,
  input wire logic BREAK_STATE,
  input wire logic SHORT_RECOVERY,
  input wire logic WATCHDOG_DISABLE,
  input wire logic PIN_RST,
  input wire logic WDOG_RST,
  input wire logic ILLEGAL_OPCODE_RST,
  input wire logic ILLEGAL_ADDRESS_RST,
  input wire logic MONITOR_ENTRY_RST,
  input wire logic LOW_VOLTAGE_RST,
  output logic CPU_CLK_EN,
  output logic BUS_CLK_EN,
  output logic XTAL_CLK_EN,
  output logic IMASK_CLEAR,
  output logic STACK_START,
  output logic WDOG_TICK,
  output logic CLEAR_ALLOWED
);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
  endfunction

  lpr_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q;
  logic rec_short_q;
  logic brk_wait_q;
  logic clr_en_q;
  logic [7:0] rc_q;
  logic [7:0] rc_set;
  logic any_rst;
  logic wake;
  logic rec_done;
  logic ack_q;
  logic req;
  logic wr_acc;
  logic rd_acc;
  logic stack_d;
  logic [7:0] rd_byte;

  assign any_rst = PIN_RST | WDOG_RST | ILLEGAL_OPCODE_RST | ILLEGAL_ADDRESS_RST |
                   MONITOR_ENTRY_RST | LOW_VOLTAGE_RST;
  assign wake = MOD_IRQ | BREAK_IRQ;
  assign rec_done = cnt_q == (rec_short_q ? RECOV_SHORT_LAST : RECOV_LONG_LAST);

  // Mode sequencing; reset sources outrank every wake-up
  always_comb begin
    state_d = state_q;
    stack_d = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (STOP_EXEC) begin
          state_d = ST_STOP;
        end else if (WAIT_EXEC) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (any_rst) begin
          state_d = ST_RUN;
        end else if (wake) begin
          state_d = ST_RUN;
          stack_d = 1'b1;
        end
      end
      ST_STOP: begin
        if (any_rst) begin
          state_d = ST_RUN;
        end else if (wake) begin
          state_d = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (any_rst) begin
          state_d = ST_RUN;
        end else if (rec_done) begin
          state_d = ST_RUN;
          stack_d = 1'b1;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= ST_RUN;
      STACK_START <= 1'b0;
      IMASK_CLEAR <= 1'b0;
    end else begin
      state_q <= state_d;
      STACK_START <= stack_d;
      IMASK_CLEAR <= (state_q == ST_RUN) && (STOP_EXEC || WAIT_EXEC);
    end
  end

  // Clock gates follow the next state so they change with the mode
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CPU_CLK_EN <= 1'b1;
      BUS_CLK_EN <= 1'b1;
      XTAL_CLK_EN <= 1'b1;
    end else begin
      CPU_CLK_EN <= state_d == ST_RUN;
      BUS_CLK_EN <= (state_d == ST_RUN) || (state_d == ST_WAIT);
      // Crystal must run during recovery so the oscillator can settle
      XTAL_CLK_EN <= state_d != ST_STOP;
    end
  end

  // Shared counter: watchdog prescaler normally, recovery timer after stop
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cnt_q <= '0;
      rec_short_q <= 1'b0;
      WDOG_TICK <= 1'b0;
    end else begin
      if (state_d == ST_STOP) begin
        cnt_q <= '0;
      end else if (state_q == ST_STOP) begin
        cnt_q <= '0;
        rec_short_q <= SHORT_RECOVERY;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
      WDOG_TICK <= (state_q == ST_RUN || state_q == ST_WAIT) && cnt_q == CNT_TOP &&
                   !WATCHDOG_DISABLE;
    end
  end

  // Avalon slave: one wait state, then waitrequest drops for one cycle
  assign req = AVS_READ || AVS_WRITE;
  assign wr_acc = AVS_WRITE && ack_q && AVS_BYTEENABLE[0];
  assign rd_acc = AVS_READ && ack_q;

  always_comb begin
    rd_byte = 8'h00;
    if (hit(AVS_ADDRESS, IDX_BRK_STATUS)) begin
      rd_byte[BRK_WAIT_BIT] = brk_wait_q;
    end else if (hit(AVS_ADDRESS, IDX_RST_CAUSE)) begin
      rd_byte = rc_q;
    end else if (hit(AVS_ADDRESS, IDX_BRK_FLAG_CTRL)) begin
      rd_byte[CLR_EN_BIT] = clr_en_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= '0;
    end else begin
      ack_q <= req && !ack_q;
      AVS_WAITREQUEST <= !(req && !ack_q);
      if (AVS_READ && !ack_q) begin
        AVS_READDATA <= {24'h000000, rd_byte};
      end
    end
  end

  // Break-wait flag; a new break wins over a software clear
  always_ff @(posedge CLK) begin
    if (!RST_N || any_rst) begin
      brk_wait_q <= 1'b0;
    end else if (state_q == ST_WAIT && BREAK_IRQ) begin
      brk_wait_q <= 1'b1;
    end else if (wr_acc && hit(AVS_ADDRESS, IDX_BRK_STATUS) && !AVS_WRITEDATA[BRK_WAIT_BIT]) begin
      brk_wait_q <= 1'b0;
    end
  end

  // Reset-cause flags accumulate; read clears, but a fresh cause survives it
  always_comb begin
    rc_set = 8'h00;
    rc_set[RC_PIN_BIT] = PIN_RST;
    rc_set[RC_WDOG_BIT] = WDOG_RST;
    rc_set[RC_ILL_OP_BIT] = ILLEGAL_OPCODE_RST;
    rc_set[RC_ILL_ADDR_BIT] = ILLEGAL_ADDRESS_RST;
    rc_set[RC_MON_BIT] = MONITOR_ENTRY_RST;
    rc_set[RC_LOW_VOLT_BIT] = LOW_VOLTAGE_RST;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rc_q <= RC_POR_VAL;
    end else if (rd_acc && hit(AVS_ADDRESS, IDX_RST_CAUSE)) begin
      rc_q <= rc_set;
    end else begin
      rc_q <= rc_q | rc_set;
    end
  end

  // Break flag-clear enable; other modules honour the qualified level
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      clr_en_q <= CLR_EN_RST;
      CLEAR_ALLOWED <= 1'b1;
    end else begin
      if (wr_acc && hit(AVS_ADDRESS, IDX_BRK_FLAG_CTRL)) begin
        clr_en_q <= AVS_WRITEDATA[CLR_EN_BIT];
      end
      // Two-step clears elsewhere stay armed; only the final step is gated
      CLEAR_ALLOWED <= !BREAK_STATE || clr_en_q;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_stop_wake;
    (state_q == ST_STOP) && !any_rst && wake;
  endsequence
  sequence s_held_recover;
    (state_q == ST_RECOVER) && (cnt_q == '0);
  endsequence

  a_stop_to_recover: assert property (s_stop_wake |=> s_held_recover)
    else $error("Stop wake did not start recovery from zero");
  a_wait_wake_stack: assert property ((state_q == ST_WAIT) && !any_rst && wake
    |=> STACK_START && CPU_CLK_EN)
    else $error("Wait wake did not stack next cycle");
  a_stop_clocks_off: assert property ((state_q == ST_STOP)
    |-> !XTAL_CLK_EN && !BUS_CLK_EN && !CPU_CLK_EN)
    else $error("Clocks running in stop");
  a_wait_clocks: assert property ((state_q == ST_WAIT)
    |-> BUS_CLK_EN && !CPU_CLK_EN)
    else $error("Wrong clocks in wait");
  a_short_recov_len: assert property ((state_q == ST_RECOVER) && rec_short_q
    |-> cnt_q <= RECOV_SHORT_LAST)
    else $error("Short recovery overran");
  a_recov_done_stack: assert property ((state_q == ST_RECOVER) && rec_done && !any_rst
    |=> STACK_START && (state_q == ST_RUN))
    else $error("Recovery end did not stack");
  a_long_recov_hold: assert property ((state_q == ST_RECOVER) && !rec_short_q &&
    (cnt_q == 12'hffe) && !any_rst |=> (state_q == ST_RECOVER))
    else $error("Long recovery ended early");
  a_entry_imask: assert property ((state_q == ST_RUN) && (STOP_EXEC || WAIT_EXEC)
    |=> IMASK_CLEAR ##1 !IMASK_CLEAR)
    else $error("Mask clear not pulsed on entry");
  a_break_wait_flag: assert property ((state_q == ST_WAIT) && BREAK_IRQ && !any_rst
    |=> brk_wait_q)
    else $error("Break in wait did not set flag");
  a_wdog_in_wait: assert property ((state_q == ST_WAIT) && (cnt_q == CNT_TOP) &&
    !WATCHDOG_DISABLE |=> WDOG_TICK)
    else $error("Watchdog tick missing in wait");
  a_rc_read_clear: assert property (rd_acc && hit(AVS_ADDRESS, IDX_RST_CAUSE) && !any_rst
    |=> rc_q == 8'h00)
    else $error("Reset cause not cleared by read");
  a_rc_keep: assert property (!(rd_acc && hit(AVS_ADDRESS, IDX_RST_CAUSE))
    |=> (rc_q & $past(rc_q)) == $past(rc_q))
    else $error("Reset cause flag lost");
  a_bus_one_wait: assert property (req && !ack_q ##1 req |-> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("Bus answer not one cycle");
  a_break_protect: assert property (BREAK_STATE && !clr_en_q |=> !CLEAR_ALLOWED)
    else $error("Clearing allowed in protected break");
  // Reset sources leave any low-power mode at once and never start stacking
  a_rst_exits_mode: assert property ((state_q != ST_RUN) && any_rst
    |=> (state_q == ST_RUN) && !STACK_START)
    else $error("Reset did not end low-power mode");
  a_wdog_quiet: assert property (WATCHDOG_DISABLE |=> !WDOG_TICK)
    else $error("Watchdog tick while disabled");

endmodule
`default_nettype wire

// ==== src/lpr_pkg.sv ====
package lpr_pkg;
  // Register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_BRK_STATUS = 16'hfe00;
  localparam logic [15:0] IDX_RST_CAUSE = 16'hfe01;
  localparam logic [15:0] IDX_BRK_FLAG_CTRL = 16'hfe03;
  localparam int ADDR_W = 18;
  // Field positions
  localparam int BRK_WAIT_BIT = 1;
  localparam int CLR_EN_BIT = 7;
  localparam int RC_POR_BIT = 7;
  localparam int RC_PIN_BIT = 6;
  localparam int RC_WDOG_BIT = 5;
  localparam int RC_ILL_OP_BIT = 4;
  localparam int RC_ILL_ADDR_BIT = 3;
  localparam int RC_MON_BIT = 2;
  localparam int RC_LOW_VOLT_BIT = 1;
  // Values after reset
  localparam logic [7:0] RC_POR_VAL = 8'h80;
  localparam logic CLR_EN_RST = 1'b0;
  // Stop recovery in crystal clock cycles
  localparam int RECOV_LONG_CYC = 4096;
  localparam int RECOV_SHORT_CYC = 32;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] RECOV_LONG_LAST = CNT_W'(RECOV_LONG_CYC - 1);
  localparam logic [CNT_W-1:0] RECOV_SHORT_LAST = CNT_W'(RECOV_SHORT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_TOP = 12'hfff;
  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER} lpr_state_t;
endpackage

// ==== tb/lpr_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpr_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go_wait,
  input wire logic go_stop,
  input wire logic wake,
  input wire logic stack_start,
  output logic wait_exec,
  output logic stop_exec,
  output logic mod_irq
);
  // Exec pulses last one cycle, as the processor issues them
  always_ff @(posedge clk) begin
    wait_exec <= rst_n & go_wait;
    stop_exec <= rst_n & go_stop;
  end
  // Request held until stacking starts; a real peripheral never drops it early
  always_ff @(posedge clk) begin
    if (!rst_n || stack_start) begin
      mod_irq <= 1'b0;
    end else if (wake) begin
      mod_irq <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lpr_pkg::*;
  localparam logic [17:0] A_BS = 18'h3f800, A_RC = 18'h3f804, A_UN = 18'h3f808;
  localparam logic [17:0] A_BC = 18'h3f80c;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, go_wait = 0, go_stop = 0, wake = 0;
  logic brk_irq = 0, brk_st = 0, short_rec = 0, wd_dis = 1;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0, rdata_s, exp;
  logic [3:0] be = 4'h1;
  logic [5:0] rsrc = '0, m;
  logic [7:0] d;
  wire logic [31:0] rdata;
  wire logic waitreq, cpu_en, bus_en, xtal_en, imask, stack, tick, clr_ok, wexec, sexec, irq;
  int err_count = 0, tests_run = 0, cycles = 0, n;
  int seed = 32'h4fdb12c3;
  lpr_top dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .WAIT_EXEC(wexec), .STOP_EXEC(sexec), .MOD_IRQ(irq),
    .BREAK_IRQ(brk_irq), .BREAK_STATE(brk_st), .SHORT_RECOVERY(short_rec),
    .WATCHDOG_DISABLE(wd_dis), .PIN_RST(rsrc[5]), .WDOG_RST(rsrc[4]),
    .ILLEGAL_OPCODE_RST(rsrc[3]), .ILLEGAL_ADDRESS_RST(rsrc[2]), .MONITOR_ENTRY_RST(rsrc[1]),
    .LOW_VOLTAGE_RST(rsrc[0]), .CPU_CLK_EN(cpu_en), .BUS_CLK_EN(bus_en), .XTAL_CLK_EN(xtal_en),
    .IMASK_CLEAR(imask), .STACK_START(stack), .WDOG_TICK(tick), .CLEAR_ALLOWED(clr_ok));
  lpr_core_model core (.clk(clk), .rst_n(rst_n), .go_wait(go_wait), .go_stop(go_stop),
    .wake(wake), .stack_start(stack), .wait_exec(wexec), .stop_exec(sexec), .mod_irq(irq));
  always #12.5 clk = ~clk;
  task automatic complete_run;
    $display("compares %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Budget covers two watchdog periods, two 4200-cycle disabled waits and one long recovery
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
    tests_run++;
    if (got !== want) begin
      err_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] dd,
                     input logic [3:0] b);
    @(posedge clk);
    rd <= !w; wr <= w; addr <= a; wdata <= dd; be <= b;
    do @(posedge clk); while (waitreq !== 1'b0);
    rdata_s = rdata;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic rchk(input logic [17:0] a, input logic [31:0] want, input string what);
    bus(1'b0, a, 32'h0, 4'h1);
    check(rdata_s, want, what);
  endtask
  task automatic enter(input logic stp);
    @(posedge clk); go_wait <= !stp; go_stop <= stp;
    @(posedge clk); go_wait <= 1'b0; go_stop <= 1'b0; n = 1;
    while (imask !== 1'b1 && n < 10) begin @(posedge clk); n++; end
    check(n, 3, "mask clear");
    check({cpu_en, bus_en, xtal_en}, stp ? 3'b000 : 3'b011, "clock enables");
  endtask
  // Count edges from the edge the design first sees the request until stacking
  task automatic wake_count;
    @(posedge clk); wake <= 1'b1;
    do @(posedge clk); while (irq !== 1'b1);
    wake <= 1'b0; n = 0;
    do begin @(posedge clk); n++; end while (stack !== 1'b1 && n < 5000);
  endtask
  task automatic tick_gap;
    n = 0;
    do begin @(posedge clk); n++; end while (tick !== 1'b1 && n < 4200);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(A_RC, 32'h80, "power-on cause");
    rchk(A_RC, 32'h0, "cause after read");
    rchk(A_BS, 32'h0, "break status");
    rchk(A_UN, 32'h0, "unmapped");
    exp = '0;
    for (int i = 0; i < 10; i++) begin
      m = (i < 6) ? 6'h1 << i : 6'($random(seed));
      @(posedge clk); rsrc <= m;
      @(posedge clk); rsrc <= '0;
      exp |= {24'h0, 1'b0, m, 1'b0};
      if (i % 2 == 1) begin
        rchk(A_RC, exp, "reset cause");
        exp = '0;
      end
    end
    $display("test registers done");
    enter(1'b0);
    wake_count();
    check(n, 1, "wait wake");
    enter(1'b0);
    @(posedge clk); brk_irq <= 1'b1;
    @(posedge clk); brk_irq <= 1'b0;
    repeat (3) @(posedge clk);
    check(cpu_en, 1'b1, "break ends wait");
    rchk(A_BS, 32'h2, "break wait flag");
    bus(1'b1, A_BS, 32'hff, 4'h1);
    rchk(A_BS, 32'h2, "flag after one");
    bus(1'b1, A_BS, 32'hfd, 4'h1);
    rchk(A_BS, 32'h0, "flag cleared");
    enter(1'b0);
    @(posedge clk); brk_irq <= 1'b1;
    @(posedge clk); brk_irq <= 1'b0;
    enter(1'b0);
    @(posedge clk); rsrc <= 6'h20;
    @(posedge clk); rsrc <= '0;
    repeat (2) @(posedge clk);
    check({cpu_en, stack}, 2'b10, "reset ends wait");
    rchk(A_BS, 32'h0, "flag after reset");
    rchk(A_RC, 32'h40, "pin cause");
    $display("test wait done");
    for (int s = 0; s < 2; s++) begin
      short_rec <= s[0];
      enter(1'b1);
      repeat (5) @(posedge clk);
      check(xtal_en, 1'b0, "stop holds");
      wake_count();
      check(n, s ? RECOV_SHORT_CYC + 1 : RECOV_LONG_CYC + 1, "recovery");
      check(cpu_en & bus_en, 1'b1, "after recovery");
    end
    $display("test stop done");
    for (int k = 0; k < 2; k++) begin
      d = {k[0], 7'($random(seed))};
      bus(1'b1, A_BC, {24'h0, d}, 4'h1);
      bus(1'b1, A_BC, {24'h0, ~d}, 4'h0);
      rchk(A_BC, {24'h0, d & 8'h80}, "clear enable reg");
      @(posedge clk); brk_st <= 1'b1;
      repeat (3) @(posedge clk);
      check(clr_ok, d[7], "clear in break");
      @(posedge clk); brk_st <= 1'b0;
      repeat (3) @(posedge clk);
      check(clr_ok, 1'b1, "clear outside break");
    end
    $display("test break clear done");
    wd_dis <= 1'b0;
    enter(1'b0);
    tick_gap();
    tick_gap();
    check(n, RECOV_LONG_CYC, "tick period in wait");
    wake_count();
    wd_dis <= 1'b1;
    tick_gap();
    tick_gap();
    check(n, 4200, "no tick when disabled");
    $display("test watchdog done");
    @(posedge clk); rsrc <= 6'h01;
    @(posedge clk); rsrc <= '0; rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(A_RC, 32'h80, "power-on clears causes");
    $display("test reset done");
    complete_run();
  end
endmodule
`default_nettype wire
